// [test_wtm_top.sv]
// Self-checking testbench of the wake-up timer with amplitude, phase and capacitance checks
`timescale 1ns/1ps
module test_wtm_top
   import wtm_pkg::*;
;
   localparam int TICKS = 10;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        meas_start;
   logic [1:0]  meas_kind;
   logic        meas_done = 1'b0;
   logic [7:0]  meas_result = 8'h00;
   logic        cap_exceed = 1'b0;
   logic [31:0] seed = 32'h61B85E9E;
   int          num_errors = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   logic [7:0]  cfg_m [2];
   logic [7:0]  ref_m [2];
   logic [7:0]  avg_m [2];
   logic [7:0]  last_m [2];
   logic [7:0]  st_exp = 8'h00;
   logic [2:0]  en_kinds = 3'h0;
   logic [1:0]  prev_kind = 2'h2;
   logic [7:0]  all_idx [9] = '{IDX_TIMER_CTRL, IDX_AMP_CFG, IDX_AMP_REF, IDX_AMP_AVG,
      IDX_AMP_LAST, IDX_PH_CFG, IDX_PH_REF, IDX_PH_AVG, IDX_PH_LAST};
   logic [7:0]  cfg_idx [2] = '{IDX_AMP_CFG, IDX_PH_CFG};
   logic [7:0]  ref_idx [2] = '{IDX_AMP_REF, IDX_PH_REF};
   logic [7:0]  avg_idx [2] = '{IDX_AMP_AVG, IDX_PH_AVG};
   logic [7:0]  last_idx [2] = '{IDX_AMP_LAST, IDX_PH_LAST};
   event        cap_ev;

   wtm_top #(.TICK_CYCLES(TICKS)) wtm_top_i (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq),
      .MEAS_START_O(meas_start), .MEAS_KIND_O(meas_kind), .MEAS_DONE_I(meas_done),
      .MEAS_RESULT_I(meas_result), .CAP_EXCEED_I(cap_exceed));

   always #5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [7:0] avg_next(logic [7:0] av, logic [7:0] res, logic [1:0] w);
      int d;
      d = int'(res) - int'(av);
      // Arithmetic shift floors negative steps as the average does
      return 8'(int'(av) + (d >>> (WEIGHT_BASE_SHIFT + int'(w))));
   endfunction

   function automatic logic exceeds(logic [7:0] res, logic [7:0] cfg, logic [7:0] rf,
      logic [7:0] av);
      int d;
      d = int'(res) - (cfg[CFG_SRC_BIT] ? int'(av) : int'(rf));
      if (d < 0)
         d = -d;
      return d > int'(cfg[CFG_THR_LSB +: 4]);
   endfunction

   function automatic logic [1:0] next_kind(logic [1:0] p);
      logic [1:0] n;
      n = p;
      for (int i = 0; i < 3; i++)
      begin
         n = (n == 2'h2) ? 2'h0 : n + 2'h1;
         if (en_kinds[n])
            return n;
      end
      return n;
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
      output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx[5:0], 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         chk("bus ready", 32'h1, 32'h0);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic e);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, idx, d, rd, er);
      chk($sformatf("write error %0h", idx), 32'(e), 32'(er));
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic e);
      logic [31:0] rd;
      logic        er;
      apb(1'b0, idx, 8'h00, rd, er);
      chk($sformatf("read error %0h", idx), 32'(e), 32'(er));
      // Data of a refused read carries no meaning
      if (!e)
         chk($sformatf("register %0h", idx), {24'h000000, exp}, rd);
   endtask

   task automatic wait_start(output int t);
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (meas_start !== 1'b1 && n < 2000);
      if (n >= 2000)
         chk("start pulse", 32'h1, 32'h0);
      t = cyc;
   endtask

   task automatic reset_and_check();
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 2; k++)
      begin
         cfg_m[k] = 8'h00;
         ref_m[k] = 8'h00;
         avg_m[k] = 8'h00;
         last_m[k] = 8'h00;
      end
      st_exp = 8'h00;
      foreach (all_idx[i]) rd_chk(all_idx[i], REG_RESET, 1'b0);
   endtask

   task automatic model(input logic [1:0] k, input logic [7:0] r, input logic c);
      logic x;
      if (k == KIND_CAP)
      begin
         if (c)
            st_exp[IRQ_CAP_BIT] = 1'b1;
      end
      else
      begin
         x = exceeds(r, cfg_m[k], ref_m[k], avg_m[k]);
         last_m[k] = r;
         if (x)
            st_exp[k + 1] = 1'b1;
         if (!x || cfg_m[k][CFG_INCL_BIT])
            avg_m[k] = avg_next(avg_m[k], r, cfg_m[k][2:1]);
      end
   endtask

   // Far side of the measurement port, answering after a random delay
   initial
   begin : responder
      logic [1:0]  k;
      logic [31:0] t;
      forever
      begin
         @(posedge clk);
         if (meas_start === 1'b1)
         begin
            k = meas_kind;
            prev_kind = next_kind(prev_kind);
            chk("measure kind", 32'(prev_kind), 32'(k));
            t = rnd();
            repeat (t[9:8]) @(posedge clk);
            meas_done <= 1'b1;
            meas_result <= t[7:0];
            cap_exceed <= t[10];
            @(posedge clk);
            meas_done <= 1'b0;
            meas_result <= ~t[7:0];
            cap_exceed <= ~t[10];
            model(k, t[7:0], t[10]);
            if (k == KIND_CAP)
               -> cap_ev;
         end
      end
   end

   initial
   begin
      #(60000 * 10);
      num_errors++;
      tally_and_finish();
   end

   initial
   begin : main
      int          t0;
      int          t1;
      logic [31:0] t;
      logic [7:0]  ctrl;
      logic [3:0]  mask;
      reset_and_check();
      wr(IDX_AMP_AVG, 8'h5A, 1'b1);
      wr(IDX_PH_LAST, 8'hA5, 1'b1);
      rd_chk(IDX_AMP_AVG, REG_RESET, 1'b0);
      rd_chk(IDX_PH_LAST, REG_RESET, 1'b0);
      rd_chk(8'h3E, 8'h00, 1'b1);
      $display("reset and access test done");
      for (int rg = 0; rg < 2; rg++)
         for (int n = 0; n < 8; n++)
         begin
            ctrl = {rg[0], n[2:0], 4'h4};
            wr(IDX_WAKE_EN, 8'h00, 1'b0);
            wr(IDX_TIMER_CTRL, ctrl, 1'b0);
            en_kinds = 3'h1;
            prev_kind = 2'h2;
            wr(IDX_WAKE_EN, 8'h01, 1'b0);
            wait_start(t0);
            repeat (2)
            begin
               wait_start(t1);
               chk("wake period", 32'((n + 1) * TICKS * (rg ? 1 : STEP_LONG_MS / STEP_SHORT_MS)),
                  32'(t1 - t0));
               t0 = t1;
            end
         end
      wr(IDX_WAKE_EN, 8'h00, 1'b0);
      repeat (20) @(posedge clk);
      $display("period test done");
      // Second reset clears what the period sweep left behind
      reset_and_check();
      for (int i = 0; i < 8; i++)
      begin
         for (int k = 0; k < 2; k++)
         begin
            t = rnd();
            cfg_m[k] = t[7:0];
            ref_m[k] = t[15:8];
            wr(cfg_idx[k], cfg_m[k], 1'b0);
            wr(ref_idx[k], ref_m[k], 1'b0);
            rd_chk(cfg_idx[k], cfg_m[k], 1'b0);
            rd_chk(ref_idx[k], ref_m[k], 1'b0);
         end
         t = rnd();
         mask = t[3:0];
         wr(IDX_IRQ_MASK, {4'h0, mask}, 1'b0);
         ctrl = {1'b1, 3'h7, t[4], t[6:5], 1'b1};
         en_kinds = {1'b1, ctrl[TMR_PH_BIT], ctrl[TMR_AMP_BIT]};
         prev_kind = 2'h2;
         wr(IDX_TIMER_CTRL, ctrl, 1'b0);
         wr(IDX_WAKE_EN, 8'h01, 1'b0);
         repeat (3) @(cap_ev);
         wr(IDX_WAKE_EN, 8'h00, 1'b0);
         if (ctrl[TMR_IRQ_BIT])
            st_exp[IRQ_TIMEOUT_BIT] = 1'b1;
         repeat (4) @(posedge clk);
         chk("irq level", 32'(|(st_exp[3:0] & mask)), 32'(irq));
         rd_chk(IDX_IRQ_STATUS, st_exp, 1'b0);
         repeat (3) @(posedge clk);
         chk("irq after clear", 32'h0, 32'(irq));
         st_exp = 8'h00;
         for (int k = 0; k < 2; k++)
         begin
            rd_chk(avg_idx[k], avg_m[k], 1'b0);
            rd_chk(last_idx[k], last_m[k], 1'b0);
         end
         $display("measurement round %0d done", i);
      end
      tally_and_finish();
   end
endmodule

// [wtm_chan.sv]
// One measurement channel: compare with reference, running average, last result
`timescale 1ns/1ps
module wtm_chan
   import wtm_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       valid_i,
   input  wire logic [7:0] result_i,
   input  wire logic [7:0] cfg_i,
   input  wire logic [7:0] reference_i,
   output logic            exceed_o,
   output logic [7:0]      average_o,
   output logic [7:0]      last_o
);
   logic [7:0] ref_sel;
   logic [7:0] diff;
   logic       exceed_now;
   logic [2:0] shift;
   logic signed [8:0] delta;
   logic signed [8:0] step;

   assign ref_sel    = cfg_i[CFG_SRC_BIT] ? average_o : reference_i; // [R11]
   assign diff       = (result_i >= ref_sel) ? result_i - ref_sel : ref_sel - result_i;
   assign exceed_now = diff > {4'h0, cfg_i[CFG_THR_LSB +: 4]}; // [R7] [R8]
   assign shift      = 3'(WEIGHT_BASE_SHIFT) + {1'b0, cfg_i[CFG_WEIGHT_LSB +: 2]}; // [R10]
   assign delta      = $signed({1'b0, result_i}) - $signed({1'b0, average_o});
   assign step       = delta >>> shift; // [R15]

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         last_o <= REG_RESET;
      else if (valid_i)
         last_o <= result_i; // [R14]
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         exceed_o <= 1'b0;
      else
         exceed_o <= valid_i && exceed_now; // [R4] [R5]
   end

   // A triggering result is kept out unless the include bit is set
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         average_o <= REG_RESET;
      else if (valid_i && (!exceed_now || cfg_i[CFG_INCL_BIT])) // [R9]
         average_o <= average_o + step[7:0]; // [R15]
   end

   property p_last_capture;
      @(posedge clk_i) disable iff (rst_i) valid_i |=> last_o == $past(result_i);
   endproperty
   a_last_capture: assert property (p_last_capture) else $error("last result not captured"); // [R14]

   property p_exceed;
      @(posedge clk_i) disable iff (rst_i)
         valid_i && (diff > {4'h0, cfg_i[7:4]}) |=> exceed_o ##1 !exceed_o;
   endproperty
   a_exceed: assert property (p_exceed) else $error("exceed pulse missing"); // [R7]

   property p_avg_excluded;
      @(posedge clk_i) disable iff (rst_i)
         valid_i && exceed_now && !cfg_i[CFG_INCL_BIT] |=> $stable(average_o);
   endproperty
   a_avg_excluded: assert property (p_avg_excluded) else $error("excluded result averaged"); // [R9]

   property p_avg_moves;
      @(posedge clk_i) disable iff (rst_i)
         valid_i && !exceed_now && ({1'b0, result_i} > {1'b0, average_o} + 9'h03F)
         |=> average_o > $past(average_o);
   endproperty
   a_avg_moves: assert property (p_avg_moves) else $error("average did not move"); // [R15]

   c_exceed: cover property (@(posedge clk_i) disable iff (rst_i) exceed_o);
endmodule

// [wtm_pkg.sv]
// Package with register map, field layout, timing and state types of the wake-up timer
package wtm_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_TIMER_CTRL = 8'h32;
   localparam logic [7:0] IDX_AMP_CFG    = 8'h33;
   localparam logic [7:0] IDX_AMP_REF    = 8'h34;
   localparam logic [7:0] IDX_AMP_AVG    = 8'h35;
   localparam logic [7:0] IDX_AMP_LAST   = 8'h36;
   localparam logic [7:0] IDX_PH_CFG     = 8'h37;
   localparam logic [7:0] IDX_PH_REF     = 8'h38;
   localparam logic [7:0] IDX_PH_AVG     = 8'h39;
   localparam logic [7:0] IDX_PH_LAST    = 8'h3A;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h3B;
   localparam logic [7:0] IDX_IRQ_MASK   = 8'h3C;
   localparam logic [7:0] IDX_WAKE_EN    = 8'h3D;
   localparam logic [7:0] REG_RESET      = 8'h00;
   // Timer control fields
   localparam int TMR_RANGE_BIT = 7;
   localparam int TMR_CODE_LSB  = 4;
   localparam int TMR_IRQ_BIT   = 3;
   localparam int TMR_AMP_BIT   = 2;
   localparam int TMR_PH_BIT    = 1;
   localparam int TMR_CAP_BIT   = 0;
   // Measurement configuration fields
   localparam int CFG_THR_LSB    = 4;
   localparam int CFG_INCL_BIT   = 3;
   localparam int CFG_WEIGHT_LSB = 1;
   localparam int CFG_SRC_BIT    = 0;
   localparam int WEIGHT_BASE_SHIFT = 2;
   // Interrupt status bits and wake-up enable bit
   localparam int IRQ_TIMEOUT_BIT = 0;
   localparam int IRQ_AMP_BIT     = 1;
   localparam int IRQ_PH_BIT      = 2;
   localparam int IRQ_CAP_BIT     = 3;
   localparam int WAKE_EN_BIT     = 0;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int STEP_SHORT_MS = 10;
   localparam int STEP_LONG_MS  = 100;
   localparam int TICK_CYCLES_DEFAULT = STEP_SHORT_MS * 1000000 / CLK_PERIOD_NS;
   localparam logic [3:0] LONG_DIV_LAST = 4'(STEP_LONG_MS / STEP_SHORT_MS - 1);
   // Measurement kinds
   localparam logic [1:0] KIND_AMP = 2'h0;
   localparam logic [1:0] KIND_PH  = 2'h1;
   localparam logic [1:0] KIND_CAP = 2'h2;
   typedef enum {SEQ_IDLE, SEQ_AMP, SEQ_PH, SEQ_CAP} wtm_seq_t;
endpackage

// [wtm_top.sv]
// Wake-up timer with amplitude, phase and capacitance checks behind an APB slave
//
// Operation
// R1 - Range bit clear gives 100 ms step, set gives 10 ms step.
// R2 - Three-bit code n gives a period of n+1 steps.
// R3 - Timeout interrupt bit set raises an interrupt on every expiry.
// R4 - Amplitude check bit starts amplitude measurement at timeout, flags large difference.
// R5 - Phase check bit starts phase measurement at timeout, flags large difference.
// R6 - Capacitance check bit starts capacitance measurement, flags its exceed result.
// R7 - Upper nibble of amplitude config is the amplitude trigger margin.
// R8 - Upper nibble of phase config is the phase trigger margin.
// R9 - Include bit decides whether a triggering result enters the average.
// R10 - Two-bit weight selects 4, 8, 16 or 32.
// R11 - Source bit picks software reference when clear, running average when set.
// R12 - Amplitude and phase reference registers are software written, reset to zero.
// R13 - Running averages are readable, zero after reset.
// R14 - Latest results are readable, zero after reset.
// R15 - Average moves by the difference to the result divided by weight.
// R16 - Timer restarts after each expiry while wake-up mode is enabled.
`timescale 1ns/1ps
module wtm_top
   import wtm_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEFAULT
)
(
   input  wire logic        CLK_I,
   input  wire logic        RST_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic [31:0]      PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   output logic             IRQ_O,
   output logic             MEAS_START_O,
   output logic [1:0]       MEAS_KIND_O,
   input  wire logic        MEAS_DONE_I,
   input  wire logic [7:0]  MEAS_RESULT_I,
   input  wire logic        CAP_EXCEED_I
);
   logic [7:0]  timer_ctrl;
   logic [7:0]  cfg [2];
   logic [7:0]  refv [2];
   logic [7:0]  avg [2];
   logic [7:0]  last [2];
   logic [1:0]  exceed;
   logic [1:0]  chan_valid;
   logic [3:0]  irq_status;
   logic [3:0]  irq_mask;
   logic        wake_en;
   logic [19:0] tick_count;
   logic        tick;
   logic [3:0]  step_div;
   logic        step_pulse;
   logic [2:0]  step_count;
   logic        timeout;
   wtm_seq_t    state;
   logic [2:0]  pend;
   logic        cap_event;
   logic [7:0]  index;
   logic        aligned;
   logic        mapped;
   logic [7:0]  rd_value;
   logic        access;
   logic        commit;
   logic        wr_commit;
   logic [3:0]  read_taken;
   logic [3:0]  next_status;
   logic [3:0]  events;
   logic [3:0]  next_mask;

   // APB decode
   assign index     = {2'b00, PADDR_I[7:2]};
   assign aligned   = PADDR_I[1:0] == 2'b00;
   assign access    = PSEL_I && PENABLE_I;
   assign commit    = access && PREADY_O;
   assign wr_commit = commit && PWRITE_I && !PSLVERR_O;

   always_comb
   begin
      mapped   = aligned;
      rd_value = REG_RESET;
      case (index)
         IDX_TIMER_CTRL: rd_value = timer_ctrl;
         IDX_AMP_CFG:    rd_value = cfg[0];
         IDX_AMP_REF:    rd_value = refv[0];
         IDX_AMP_AVG:    rd_value = avg[0]; // [R13]
         IDX_AMP_LAST:   rd_value = last[0]; // [R14]
         IDX_PH_CFG:     rd_value = cfg[1];
         IDX_PH_REF:     rd_value = refv[1];
         IDX_PH_AVG:     rd_value = avg[1]; // [R13]
         IDX_PH_LAST:    rd_value = last[1]; // [R14]
         IDX_IRQ_STATUS: rd_value = {4'h0, irq_status};
         IDX_IRQ_MASK:   rd_value = {4'h0, irq_mask};
         IDX_WAKE_EN:    rd_value = {7'h00, wake_en};
         default:        mapped   = 1'b0;
      endcase
   end

   // Answer one cycle into the access phase so that read data comes from a flop
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
         PREADY_O <= 1'b0;
      else
         PREADY_O <= access && !PREADY_O;
   end

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         PRDATA_O  <= 32'h00000000;
         PSLVERR_O <= 1'b0;
      end
      else if (access && !PREADY_O)
      begin
         PRDATA_O  <= PWRITE_I ? 32'h00000000 : {24'h000000, rd_value};
         PSLVERR_O <= !mapped || (PWRITE_I && (index == IDX_AMP_AVG || index == IDX_AMP_LAST
                      || index == IDX_PH_AVG || index == IDX_PH_LAST
                      || index == IDX_IRQ_STATUS));
      end
   end

   // Software registers
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         timer_ctrl <= REG_RESET;
         irq_mask   <= 4'h0;
         wake_en    <= 1'b0;
      end
      else if (wr_commit)
      begin
         if (index == IDX_TIMER_CTRL)
            timer_ctrl <= PWDATA_I[7:0];
         if (index == IDX_IRQ_MASK)
            irq_mask <= PWDATA_I[3:0];
         if (index == IDX_WAKE_EN)
            wake_en <= PWDATA_I[WAKE_EN_BIT];
      end
   end

   // Per-channel configuration, reference and result logic
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++)
      begin : g_chan
         localparam logic [7:0] CFG_IDX = (ch == 0) ? IDX_AMP_CFG : IDX_PH_CFG;
         localparam logic [7:0] REF_IDX = (ch == 0) ? IDX_AMP_REF : IDX_PH_REF;

         always_ff @(posedge CLK_I)
         begin
            if (RST_I)
            begin
               cfg[ch]  <= REG_RESET;
               refv[ch] <= REG_RESET; // [R12]
            end
            else if (wr_commit)
            begin
               if (index == CFG_IDX)
                  cfg[ch] <= PWDATA_I[7:0];
               if (index == REF_IDX)
                  refv[ch] <= PWDATA_I[7:0]; // [R12]
            end
         end

         assign chan_valid[ch] = MEAS_DONE_I && (state == ((ch == 0) ? SEQ_AMP : SEQ_PH));

         wtm_chan u_chan
         (
            .clk_i       (CLK_I),
            .rst_i       (RST_I),
            .valid_i     (chan_valid[ch]),
            .result_i    (MEAS_RESULT_I),
            .cfg_i       (cfg[ch]),
            .reference_i (refv[ch]),
            .exceed_o    (exceed[ch]),
            .average_o   (avg[ch]),
            .last_o      (last[ch])
         );
      end
   endgenerate

   // 10 ms tick divider; stopped and cleared outside wake-up mode
   assign tick = tick_count == 20'(TICK_CYCLES - 1);

   always_ff @(posedge CLK_I)
   begin
      if (RST_I || !wake_en || tick)
         tick_count <= 20'h00000;
      else
         tick_count <= tick_count + 20'h00001;
   end

   assign step_pulse = wake_en && tick && (timer_ctrl[TMR_RANGE_BIT] || step_div == LONG_DIV_LAST); // [R1]

   always_ff @(posedge CLK_I)
   begin
      if (RST_I || !wake_en)
         step_div <= 4'h0;
      else if (tick)
         step_div <= (step_div == LONG_DIV_LAST) ? 4'h0 : step_div + 4'h1; // [R1]
   end

   assign timeout = step_pulse && step_count == timer_ctrl[TMR_CODE_LSB +: 3]; // [R2]

   always_ff @(posedge CLK_I)
   begin
      if (RST_I || !wake_en)
         step_count <= 3'h0;
      else if (timeout)
         step_count <= 3'h0; // [R16]
      else if (step_pulse)
         step_count <= step_count + 3'h1;
   end

   // Measurement sequencing; a timeout during a running sequence is skipped
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
         pend <= 3'h0;
      else if (timeout && state == SEQ_IDLE && pend == 3'h0)
         pend <= {timer_ctrl[TMR_AMP_BIT], timer_ctrl[TMR_PH_BIT], timer_ctrl[TMR_CAP_BIT]}; // [R4] [R5] [R6]
      else if (MEAS_DONE_I)
         case (state)
            SEQ_AMP: pend[2] <= 1'b0;
            SEQ_PH:  pend[1] <= 1'b0;
            SEQ_CAP: pend[0] <= 1'b0;
            default: pend    <= pend;
         endcase
   end

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
         state <= SEQ_IDLE;
      else
         case (state)
            SEQ_IDLE:
               if (pend[2])
                  state <= SEQ_AMP; // [R4]
               else if (pend[1])
                  state <= SEQ_PH; // [R5]
               else if (pend[0])
                  state <= SEQ_CAP; // [R6]
            SEQ_AMP, SEQ_PH, SEQ_CAP:
               if (MEAS_DONE_I)
                  state <= SEQ_IDLE;
            default:
               state <= SEQ_IDLE;
         endcase
   end

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         MEAS_START_O <= 1'b0;
         MEAS_KIND_O  <= KIND_AMP;
      end
      else
      begin
         MEAS_START_O <= state == SEQ_IDLE && pend != 3'h0;
         // Kind stays put between starts so the far side may read it late
         if (state == SEQ_IDLE && pend != 3'h0)
            MEAS_KIND_O <= pend[2] ? KIND_AMP : (pend[1] ? KIND_PH : KIND_CAP);
      end
   end

   assign cap_event = MEAS_DONE_I && state == SEQ_CAP && CAP_EXCEED_I; // [R6]

   // Interrupt status; a read clears only the bits it returned, so new events win
   always_comb
   begin
      events = 4'h0;
      events[IRQ_TIMEOUT_BIT] = timeout && timer_ctrl[TMR_IRQ_BIT]; // [R3]
      events[IRQ_AMP_BIT]     = exceed[0]; // [R4]
      events[IRQ_PH_BIT]      = exceed[1]; // [R5]
      events[IRQ_CAP_BIT]     = cap_event; // [R6]
      read_taken = 4'h0;
      if (commit && !PWRITE_I && !PSLVERR_O && index == IDX_IRQ_STATUS)
         read_taken = PRDATA_O[3:0];
      next_status = (irq_status & ~read_taken) | events;
      // A mask written now already counts, so the output never lags the mask
      next_mask = (wr_commit && index == IDX_IRQ_MASK) ? PWDATA_I[3:0] : irq_mask;
   end

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
         irq_status <= 4'h0;
      else
         irq_status <= next_status;
   end

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
         IRQ_O <= 1'b0;
      else
         IRQ_O <= |(next_status & next_mask);
   end

   property p_timeout_irq;
      @(posedge CLK_I) disable iff (RST_I)
         timeout && timer_ctrl[TMR_IRQ_BIT] |=> irq_status[IRQ_TIMEOUT_BIT];
   endproperty
   a_timeout_irq: assert property (p_timeout_irq) else $error("timeout status not set"); // [R3]

   property p_no_timeout_irq;
      @(posedge CLK_I) disable iff (RST_I)
         timeout && !timer_ctrl[TMR_IRQ_BIT] && !irq_status[IRQ_TIMEOUT_BIT]
         |=> !irq_status[IRQ_TIMEOUT_BIT];
   endproperty
   a_no_timeout_irq: assert property (p_no_timeout_irq) else $error("timeout status spurious"); // [R3]

   property p_long_range;
      @(posedge CLK_I) disable iff (RST_I)
         step_pulse && !timer_ctrl[TMR_RANGE_BIT] |-> tick && step_div == 4'h9;
   endproperty
   a_long_range: assert property (p_long_range) else $error("100 ms step wrong"); // [R1]

   property p_restart;
      @(posedge CLK_I) disable iff (RST_I)
         timeout && wake_en |=> step_count == 3'h0 && tick_count == 20'h00000;
   endproperty
   a_restart: assert property (p_restart) else $error("timer not restarted"); // [R16]

   property p_amp_start;
      @(posedge CLK_I) disable iff (RST_I)
         timeout && timer_ctrl[TMR_AMP_BIT] && state == SEQ_IDLE && pend == 3'h0
         |=> ##1 MEAS_START_O && MEAS_KIND_O == KIND_AMP;
   endproperty
   a_amp_start: assert property (p_amp_start) else $error("amplitude measurement not started"); // [R4]

   property p_ref_write;
      @(posedge CLK_I) disable iff (RST_I)
         wr_commit && index == IDX_PH_REF |=> refv[1] == $past(PWDATA_I[7:0]);
   endproperty
   a_ref_write: assert property (p_ref_write) else $error("phase reference not written"); // [R12]

   property p_irq_out;
      @(posedge CLK_I) disable iff (RST_I)
         |(irq_status & irq_mask) && !commit |-> IRQ_O;
   endproperty
   a_irq_out: assert property (p_irq_out) else $error("interrupt output low"); // [R3]

   c_timeout: cover property (@(posedge CLK_I) disable iff (RST_I) timeout);
   c_cap: cover property (@(posedge CLK_I) disable iff (RST_I) cap_event);
   c_read_clear: cover property (@(posedge CLK_I) disable iff (RST_I) read_taken != 4'h0);
endmodule
